// ---- design/scb_cfg_bank.sv ----
// Configuration byte bank: stored bytes with writable masks and
// registered read data.
// Assumes writes and index come from the serial engine on sys_clk.
`timescale 1ns/1ps
`include "scb_map.svh"

module scb_cfg_bank
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire scb_pkg::scb_byte_type wr_idx,
   input wire scb_pkg::scb_byte_type wr_data,
   input wire scb_pkg::scb_byte_type rd_idx,
   input wire logic [1:0] strap_mode,
   output scb_pkg::scb_byte_type rd_data_ff,
   output scb_pkg::scb_byte_type out_en_byte,
   output scb_pkg::scb_byte_type pll_byte,
   output scb_pkg::scb_byte_type slew_byte,
   output scb_pkg::scb_byte_type freq_byte,
   output scb_pkg::scb_byte_type stop_byte
);
   import scb_pkg::*;

   localparam int NSLOT = 6;
   localparam logic [2:0] NO_SLOT = 3'h7;
   localparam scb_byte_type RST [NSLOT] = '{`SCB_RST_OUT_EN, `SCB_RST_PLL,
      `SCB_RST_SLEW, `SCB_RST_FREQ, `SCB_RST_RSVD4, `SCB_RST_STOP};
   localparam scb_byte_type MSK [NSLOT] = '{`SCB_MSK_OUT_EN, `SCB_MSK_PLL,
      `SCB_MSK_SLEW, `SCB_MSK_FREQ, `SCB_MSK_RSVD4, `SCB_MSK_STOP};

   scb_byte_type bank_ff [NSLOT];
   scb_byte_type nxt_rd_data;
   logic [2:0] wr_slot;
   logic [2:0] rd_slot;

   // -----------------------------------------------------------------------
   // Index decode
   // -----------------------------------------------------------------------
   function automatic logic [2:0] slot_of(input scb_byte_type idx);
      logic [2:0] s;
      s = NO_SLOT;
      if (idx == `SCB_IDX_OUT_EN) s = 3'h0;
      if (idx == `SCB_IDX_PLL) s = 3'h1;
      if (idx == `SCB_IDX_SLEW) s = 3'h2;
      if (idx == `SCB_IDX_FREQ) s = 3'h3;
      if (idx == `SCB_IDX_RSVD4) s = 3'h4;
      if (idx == `SCB_IDX_STOP) s = 3'h5;
      return s;
   endfunction

   assign wr_slot = slot_of(wr_idx);
   assign rd_slot = slot_of(rd_idx);

   // -----------------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------------
   for (genvar g = 0; g < NSLOT; g++)
   begin : g_slot
      always_ff @(posedge sys_clk)
      begin
         if (!rst_n)
            bank_ff[g] <= RST[g];
         else if (wr_en && wr_slot == 3'(g))
            bank_ff[g] <= (wr_data & MSK[g]) | (bank_ff[g] & ~MSK[g]); // R15
      end
   end

   // -----------------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------------
   always_comb
   begin
      nxt_rd_data = 8'h00;
      if (rd_slot != NO_SLOT)
         nxt_rd_data = bank_ff[rd_slot];
      if (rd_slot == 3'h1)
      begin
         nxt_rd_data[`SCB_PLL_LATCH_HI] = strap_mode[1]; // R07
         nxt_rd_data[`SCB_PLL_LATCH_LO] = strap_mode[0]; // R07
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         rd_data_ff <= 8'h00;
      else
         rd_data_ff <= nxt_rd_data;
   end

   assign out_en_byte = bank_ff[0];
   assign pll_byte = bank_ff[1];
   assign slew_byte = bank_ff[2];
   assign freq_byte = bank_ff[3];
   assign stop_byte = bank_ff[5];

endmodule

// ---- design/scb_map.svh ----
// Offsets, field positions, power-up values and counts of the configuration
// target. Included by the design files; defines only.
//
// Notes on behaviour
// R01: Device is a target only, one 7-bit address, block read and write only.
// R02: Host may stop after any whole byte; bytes already written are kept.
// R03: Address is 1101 plus three low bits latched once from the select pin.
// R04: Write: address, index N, count X, X data bytes; every byte acknowledged.
// R05: Read: index by write, repeated start, device sends count then data.
// R06: Byte 0 bits 4,3 enable outputs; zero forces the byte 11 disable state.
// R07: Byte 1 bits 7:6 show PLL mode latched at power-up; writes ignored.
// R08: Byte 1 bit 5 picks PLL mode from bits 7:6 or from bits 4:3.
// R09: Byte 1 bits 4:3 reset to 00 and act only when bit 5 is set.
// R10: Byte 1 bits 1:0 select output swing, power-up value 10.
// R11: Byte 2 bits 4,3 set output edge speed, one is fast, reset one.
// R12: Byte 3 bit 5 enables frequency code bits 4:3, both reset to zero.
// R13: Byte 3 bit 0 sets feedback edge speed, one is fast, reset one.
// R14: Byte 11 bits 1:0 give disabled output levels: LL, HiZ, HL, LH.
// R15: Index advances per data byte; reserved bits keep power-up values.
// R16: PLL mode and frequency codes go out as opaque two-bit values.
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH

// -----------------------------------------------------------------------
// Addressing and transfer
// -----------------------------------------------------------------------
`define SCB_ADDR_HI 4'hD
`define SCB_READ_COUNT 8'h0C
`define SCB_CAP_CYCLES 3'h4
`define SCB_PIN_IDLE 9'h00F

// -----------------------------------------------------------------------
// Register indices
// -----------------------------------------------------------------------
`define SCB_IDX_OUT_EN 8'h00
`define SCB_IDX_PLL 8'h01
`define SCB_IDX_SLEW 8'h02
`define SCB_IDX_FREQ 8'h03
`define SCB_IDX_RSVD4 8'h04
`define SCB_IDX_STOP 8'h0B

// -----------------------------------------------------------------------
// Power-up values and writable masks
// -----------------------------------------------------------------------
`define SCB_RST_OUT_EN 8'h18
`define SCB_MSK_OUT_EN 8'h18
`define SCB_RST_PLL 8'h06
`define SCB_MSK_PLL 8'h3B
`define SCB_RST_SLEW 8'hFF
`define SCB_MSK_SLEW 8'h18
`define SCB_RST_FREQ 8'hC7
`define SCB_MSK_FREQ 8'h39
`define SCB_RST_RSVD4 8'hFF
`define SCB_MSK_RSVD4 8'h00
`define SCB_RST_STOP 8'h80
`define SCB_MSK_STOP 8'h03

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define SCB_OE1_BIT 4
`define SCB_OE0_BIT 3
`define SCB_PLL_LATCH_HI 7
`define SCB_PLL_LATCH_LO 6
`define SCB_PLL_SW_BIT 5
`define SCB_PLL_SW_HI 4
`define SCB_PLL_SW_LO 3
`define SCB_SWING_HI 1
`define SCB_SWING_LO 0
`define SCB_EDGE1_BIT 4
`define SCB_EDGE0_BIT 3
`define SCB_FREQ_EN_BIT 5
`define SCB_FREQ_HI 4
`define SCB_FREQ_LO 3
`define SCB_FB_EDGE_BIT 0
`define SCB_DIS_HI 1
`define SCB_DIS_LO 0

`endif

// ---- design/scb_pkg.sv ----
// Types shared by the configuration target.
// Assumes scb_map.svh holds all numbers.
package scb_pkg;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_RX = 6'b000100,
      ST_ACK = 6'b001000,
      ST_TX = 6'b010000,
      ST_HACK = 6'b100000
   } scb_state_type;

   typedef logic [7:0] scb_byte_type;

endpackage

// ---- design/scb_smbus_target.sv ----
// SMBus block-read/block-write configuration target and the control
// outputs that the stored bytes steer.
// Assumes scl and sda arrive from pins; the host never stretches the clock.
`timescale 1ns/1ps
`include "scb_map.svh"

module scb_smbus_target
#(
   parameter logic [7:0] READ_COUNT = `SCB_READ_COUNT
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [2:0] addr_select_pin,
   input wire logic [1:0] pll_mode_strap,
   input wire logic [1:0] oe_pin_n,
   output logic [1:0] out_active,
   output logic dis_true_high,
   output logic dis_comp_high,
   output logic dis_hiz,
   output logic [1:0] pll_mode_eff,
   output logic [1:0] swing_sel,
   output logic [1:0] out_edge_speed,
   output logic freq_sw_en,
   output logic [1:0] freq_code,
   output logic feedback_edge_speed
);
   import scb_pkg::*;

   if (READ_COUNT == 8'h00)
   begin : g_bad_count
      $error("READ_COUNT must be at least one");
   end

   logic [8:0] pins;
   logic [8:0] pin_s1_ff;
   logic [8:0] pin_s2_ff;
   logic [8:0] pin_s3_ff;
   logic [8:0] pin_f_ff;
   logic scl_f;
   logic sda_f;
   logic scl_prev_ff;
   logic sda_prev_ff;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [2:0] cap_cnt_ff;
   logic cap_done_ff;
   logic [2:0] addr_lo_ff;
   logic [1:0] strap_mode_ff;
   scb_state_type state_ff;
   logic [2:0] bit_cnt_ff;
   scb_byte_type shift_ff;
   logic full_ff;
   logic rw_ff;
   logic [1:0] byte_num_ff;
   scb_byte_type idx_ff;
   scb_byte_type remain_ff;
   logic cnt_sent_ff;
   logic sda_oe_ff;
   logic nxt_sda_oe;
   logic wr_en;
   scb_byte_type rd_data;
   scb_byte_type out_en_byte;
   scb_byte_type pll_byte;
   scb_byte_type slew_byte;
   scb_byte_type freq_byte;
   scb_byte_type stop_byte;

   // -----------------------------------------------------------------------
   // Pin synchronisers with agreement filter
   // -----------------------------------------------------------------------
   assign pins = {pll_mode_strap, addr_select_pin, oe_pin_n, sda_in, scl_in};

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pin_s1_ff <= `SCB_PIN_IDLE;
         pin_s2_ff <= `SCB_PIN_IDLE;
         pin_s3_ff <= `SCB_PIN_IDLE;
         pin_f_ff <= `SCB_PIN_IDLE;
      end
      else
      begin
         pin_s1_ff <= pins;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         pin_f_ff <= (pin_s2_ff & pin_s3_ff)
            | (pin_f_ff & (pin_s2_ff | pin_s3_ff));
      end
   end

   assign scl_f = pin_f_ff[0];
   assign sda_f = pin_f_ff[1];

   // -----------------------------------------------------------------------
   // Bus events
   // -----------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end
      else
      begin
         scl_prev_ff <= scl_f;
         sda_prev_ff <= sda_f;
      end
   end

   assign scl_rise = scl_f & ~scl_prev_ff;
   assign scl_fall = ~scl_f & scl_prev_ff;
   assign start_cond = scl_f & scl_prev_ff & sda_prev_ff & ~sda_f;
   assign stop_cond = scl_f & scl_prev_ff & ~sda_prev_ff & sda_f;

   // -----------------------------------------------------------------------
   // Strap capture once the filter output holds the real pin levels
   // -----------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cap_cnt_ff <= 3'h0;
         cap_done_ff <= 1'b0;
         addr_lo_ff <= 3'h0;
         strap_mode_ff <= 2'h0;
      end
      else if (!cap_done_ff)
      begin
         if (cap_cnt_ff == `SCB_CAP_CYCLES)
         begin
            cap_done_ff <= 1'b1;
            addr_lo_ff <= pin_f_ff[6:4]; // R03
            strap_mode_ff <= pin_f_ff[8:7]; // R07
         end
         else
            cap_cnt_ff <= cap_cnt_ff + 3'h1;
      end
   end

   // -----------------------------------------------------------------------
   // Serial engine
   // -----------------------------------------------------------------------
   assign wr_en = (state_ff == ST_RX) && scl_fall && full_ff && !rw_ff
      && byte_num_ff == 2'h2 && remain_ff != 8'h00; // R04

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 3'h0;
         shift_ff <= 8'hFF;
         full_ff <= 1'b0;
         rw_ff <= 1'b0;
         byte_num_ff <= 2'h0;
         idx_ff <= 8'h00;
         remain_ff <= 8'h00;
         cnt_sent_ff <= 1'b0;
      end
      else if (start_cond)
      begin
         state_ff <= ST_ADDR;
         bit_cnt_ff <= 3'h0;
         full_ff <= 1'b0;
      end
      else if (stop_cond)
      begin
         state_ff <= ST_IDLE; // R02
         full_ff <= 1'b0;
      end
      else
      begin
         unique case (state_ff)
            ST_IDLE:
            begin
               full_ff <= 1'b0;
            end
            ST_ADDR, ST_RX:
            begin
               if (scl_rise && !full_ff)
               begin
                  shift_ff <= {shift_ff[6:0], sda_f};
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
                  full_ff <= (bit_cnt_ff == 3'h7);
               end
               else if (scl_fall && full_ff)
               begin
                  full_ff <= 1'b0;
                  state_ff <= ST_ACK; // R04
                  if (state_ff == ST_ADDR)
                  begin
                     if (shift_ff[7:1] != {`SCB_ADDR_HI, addr_lo_ff}) // R01
                        state_ff <= ST_IDLE;
                     rw_ff <= shift_ff[0];
                     cnt_sent_ff <= 1'b0;
                     if (!shift_ff[0])
                        byte_num_ff <= 2'h0;
                  end
                  else
                  begin
                     if (byte_num_ff == 2'h0)
                        idx_ff <= shift_ff;
                     else if (byte_num_ff == 2'h1)
                        remain_ff <= shift_ff;
                     else if (remain_ff != 8'h00)
                     begin
                        idx_ff <= idx_ff + 8'h01; // R15
                        remain_ff <= remain_ff - 8'h01;
                     end
                     if (byte_num_ff != 2'h2)
                        byte_num_ff <= byte_num_ff + 2'h1;
                  end
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  bit_cnt_ff <= 3'h0;
                  if (rw_ff)
                  begin
                     state_ff <= ST_TX; // R05
                     cnt_sent_ff <= 1'b1;
                     shift_ff <= cnt_sent_ff ? rd_data : READ_COUNT;
                     if (cnt_sent_ff)
                        idx_ff <= idx_ff + 8'h01; // R15
                  end
                  else
                     state_ff <= ST_RX;
               end
            end
            ST_TX:
            begin
               if (scl_rise && !full_ff)
               begin
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
                  full_ff <= (bit_cnt_ff == 3'h7);
               end
               else if (scl_fall && full_ff)
               begin
                  full_ff <= 1'b0;
                  state_ff <= ST_HACK;
               end
               else if (scl_fall)
                  shift_ff <= {shift_ff[6:0], 1'b1};
            end
            ST_HACK:
            begin
               if (scl_rise && sda_f)
                  state_ff <= ST_IDLE; // R05
               else if (scl_fall)
               begin
                  state_ff <= ST_TX;
                  bit_cnt_ff <= 3'h0;
                  shift_ff <= rd_data;
                  idx_ff <= idx_ff + 8'h01; // R15
               end
            end
         endcase
      end
   end

   // -----------------------------------------------------------------------
   // Open-drain data drive
   // -----------------------------------------------------------------------
   assign nxt_sda_oe = (state_ff == ST_ACK)
      || (state_ff == ST_TX && !shift_ff[7]);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         sda_oe_ff <= 1'b0;
      else
         sda_oe_ff <= nxt_sda_oe; // R04
   end

   assign sda_oe = sda_oe_ff;
   assign sda_out = 1'b0;

   // -----------------------------------------------------------------------
   // Configuration bytes
   // -----------------------------------------------------------------------
   scb_cfg_bank u_bank
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wr_en(wr_en),
      .wr_idx(idx_ff),
      .wr_data(shift_ff),
      .rd_idx(idx_ff),
      .strap_mode(strap_mode_ff),
      .rd_data_ff(rd_data),
      .out_en_byte(out_en_byte),
      .pll_byte(pll_byte),
      .slew_byte(slew_byte),
      .freq_byte(freq_byte),
      .stop_byte(stop_byte)
   );

   // -----------------------------------------------------------------------
   // Control outputs to the clock path
   // -----------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         out_active <= 2'h0;
         dis_true_high <= 1'b0;
         dis_comp_high <= 1'b0;
         dis_hiz <= 1'b0;
         pll_mode_eff <= 2'h0;
         swing_sel <= 2'h2;
         out_edge_speed <= 2'h3;
         freq_sw_en <= 1'b0;
         freq_code <= 2'h0;
         feedback_edge_speed <= 1'b1;
      end
      else
      begin
         out_active <= {out_en_byte[`SCB_OE1_BIT] & ~pin_f_ff[3],
            out_en_byte[`SCB_OE0_BIT] & ~pin_f_ff[2]}; // R06
         dis_true_high <= stop_byte[`SCB_DIS_HI:`SCB_DIS_LO] == 2'h2; // R14
         dis_comp_high <= stop_byte[`SCB_DIS_HI:`SCB_DIS_LO] == 2'h3; // R14
         dis_hiz <= stop_byte[`SCB_DIS_HI:`SCB_DIS_LO] == 2'h1; // R14
         pll_mode_eff <= pll_byte[`SCB_PLL_SW_BIT] // R08 R09 R16
            ? pll_byte[`SCB_PLL_SW_HI:`SCB_PLL_SW_LO] : strap_mode_ff;
         swing_sel <= pll_byte[`SCB_SWING_HI:`SCB_SWING_LO]; // R10
         out_edge_speed <= {slew_byte[`SCB_EDGE1_BIT],
            slew_byte[`SCB_EDGE0_BIT]}; // R11
         freq_sw_en <= freq_byte[`SCB_FREQ_EN_BIT]; // R12
         freq_code <= freq_byte[`SCB_FREQ_EN_BIT] // R12 R16
            ? freq_byte[`SCB_FREQ_HI:`SCB_FREQ_LO] : 2'h0;
         feedback_edge_speed <= freq_byte[`SCB_FB_EDGE_BIT]; // R13
      end
   end

endmodule

// ---- sim/scb_host_model.sv ----
// Behavioural SMBus host driving SCL and its side of SDA.
// Assumes SDA is open drain with a pull-up; the target only pulls low.
`timescale 1ns/1ps
module scb_host_model
(
   input wire logic sys_clk,
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   logic drv_ff;
   assign sda = drv_ff & ~sda_oe;
   initial
   begin
      scl = 1'b1;
      drv_ff = 1'b1;
   end
   // One SCL period; data moves mid low phase, sampled late in high
   task automatic bit_io(input logic b, output logic s);
      scl <= 1'b0;
      repeat (4) @(posedge sys_clk);
      drv_ff <= b;
      repeat (6) @(posedge sys_clk);
      scl <= 1'b1;
      repeat (7) @(posedge sys_clk);
      s = sda;
      @(posedge sys_clk);
   endtask
   // Start and repeated start alike
   task automatic start();
      logic s;
      bit_io(1'b1, s);
      drv_ff <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic stop();
      logic s;
      bit_io(1'b0, s);
      drv_ff <= 1'b1;
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic xfer(input logic [7:0] d, input logic rd,
      input logic last, output logic [7:0] r, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], s);
         r[i] = s;
      end
      bit_io(rd ? last : 1'b1, s);
      ack = ~s;
   endtask
endmodule

// ---- sim/scb_smbus_target_sva.sv ----
// Checker on the ports of the configuration target.
// Assumes SCL phases of eight or more sys_clk cycles.
`timescale 1ns/1ps
module scb_smbus_target_sva
#(
   parameter logic [7:0] READ_COUNT = 8'h0C
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [1:0] oe_pin_n,
   input wire logic [1:0] out_active,
   input wire logic dis_true_high,
   input wire logic dis_comp_high,
   input wire logic dis_hiz,
   input wire logic [1:0] pll_mode_eff,
   input wire logic [1:0] swing_sel,
   input wire logic [1:0] out_edge_speed,
   input wire logic freq_sw_en,
   input wire logic [1:0] freq_code,
   input wire logic feedback_edge_speed
);
   logic scl_q_ff;
   logic [7:0] fall_cnt_ff;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // ------
   // Cycles since the last SCL fall
   // ------
   always_ff @(posedge sys_clk)
   begin
      scl_q_ff <= scl_in;
      if (!rst_n || (scl_q_ff && !scl_in))
         fall_cnt_ff <= 8'h00;
      else if (fall_cnt_ff != 8'hFF)
         fall_cnt_ff <= fall_cnt_ff + 8'h01;
   end
   // ------
   // Assertions
   // ------
   chk_sda_low_only: assert property (sda_out == 1'b0)
      else $error("sda_out driven high");
   chk_reset_values: assert property (
      $rose(rst_n) |-> swing_sel == 2'b10 && out_edge_speed == 2'b11
      && feedback_edge_speed && !freq_sw_en && out_active == 2'b00)
      else $error("control outputs wrong after reset");
   chk_freq_gated: assert property (
      !freq_sw_en |-> freq_code == 2'b00)
      else $error("frequency code passed while disabled");
   chk_dis_decode: assert property (
      $onehot0({dis_true_high, dis_comp_high, dis_hiz}))
      else $error("disable state decode not exclusive");
   chk_pin_gate: assert property (
      (oe_pin_n == 2'b11) [*8] |-> out_active == 2'b00)
      else $error("output active with enable pins high");
   chk_ack_stands: assert property (
      $rose(sda_oe) |-> sda_oe [*8])
      else $error("SDA pull released early");
   chk_sda_scl_low: assert property (
      $changed(sda_oe) |-> !scl_in)
      else $error("SDA drive changed while SCL high");
   chk_ctrl_after_fall: assert property (
      $changed({pll_mode_eff, swing_sel, out_edge_speed, freq_sw_en,
      freq_code, feedback_edge_speed, dis_hiz, dis_true_high,
      dis_comp_high}) |-> fall_cnt_ff < 8'h0C)
      else $error("control output changed away from a byte end");
endmodule
bind scb_smbus_target scb_smbus_target_sva #(.READ_COUNT(READ_COUNT)) u_chk
(
   .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .oe_pin_n(oe_pin_n), .out_active(out_active),
   .dis_true_high(dis_true_high), .dis_comp_high(dis_comp_high),
   .dis_hiz(dis_hiz), .pll_mode_eff(pll_mode_eff), .swing_sel(swing_sel),
   .out_edge_speed(out_edge_speed), .freq_sw_en(freq_sw_en),
   .freq_code(freq_code), .feedback_edge_speed(feedback_edge_speed)
);

// ---- sim/smbus_config_target_bank_test.sv ----
// Self-checking bench for the SMBus configuration target.
// Assumes the host model owns SCL and the host side of SDA.
`timescale 1ns/1ps
module smbus_config_target_bank_test;
   import scb_pkg::*;
   localparam scb_byte_type RC = 8'h05;
   localparam scb_byte_type WM [12] = '{8'h18, 8'h3B, 8'h18, 8'h39,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
   localparam logic [2:0] DZ [4] = '{3'b000, 3'b001, 3'b100, 3'b010};
   logic sys_clk = 1'b0;
   logic rst_n, scl_in, sda_in, sda_out, sda_oe, a;
   logic [2:0] addr_select_pin, sel;
   logic [1:0] pll_mode_strap, oe_pin_n, out_active, strap, code;
   logic dis_true_high, dis_comp_high, dis_hiz, freq_sw_en;
   logic [1:0] pll_mode_eff, swing_sel, out_edge_speed, freq_code;
   logic feedback_edge_speed;
   logic [31:0] rng, rv;
   scb_byte_type sh [12];
   scb_byte_type d;
   int failures = 0;
   int cmp_count = 0;
   scb_host_model host (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl_in),
      .sda(sda_in));
   scb_smbus_target #(.READ_COUNT(RC)) uut (.*);
   always #12.5 sys_clk = ~sys_clk;
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   task automatic check(input scb_byte_type got, input scb_byte_type exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check_outs();
      logic [1:0] pe;
      logic [1:0] fc;
      pe = sh[1][5] ? sh[1][4:3] : strap;
      fc = sh[3][5] ? sh[3][4:3] : 2'b00;
      check({6'h00, swing_sel}, {6'h00, sh[1][1:0]});
      check({6'h00, pll_mode_eff}, {6'h00, pe});
      check({6'h00, out_edge_speed}, {6'h00, sh[2][4:3]});
      check({7'h00, feedback_edge_speed}, {7'h00, sh[3][0]});
      check({5'h00, freq_sw_en, freq_code}, {5'h00, sh[3][5], fc});
      check({6'h00, out_active}, {6'h00, sh[0][4:3] & ~oe_pin_n});
      check({5'h00, dis_true_high, dis_comp_high, dis_hiz},
         {5'h00, DZ[sh[11][1:0]]});
   endtask
   task automatic send(input scb_byte_type v);
      scb_byte_type r;
      logic k;
      host.xfer(v, 1'b0, 1'b0, r, k);
      check({7'h00, k}, 8'h01);
   endtask
   task automatic wr_blk(input scb_byte_type n, input int x, input int cnt);
      scb_byte_type i;
      logic [3:0] j;
      host.start();
      send({4'b1101, sel, 1'b0});
      send(n);
      send(x[7:0]);
      for (int k = 0; k < cnt; k++)
      begin
         rv = rnd();
         i = n + k[7:0];
         j = i[3:0];
         if (i == 8'h0B)
            rv[1:0] = code;
         if (k < x && i < 8'h0C)
            sh[j] = (sh[j] & ~WM[j]) | (rv[7:0] & WM[j]);
         send(rv[7:0]);
      end
      host.stop();
   endtask
   task automatic rd_blk(input scb_byte_type n, input int cnt);
      scb_byte_type r;
      scb_byte_type i;
      logic k;
      host.start();
      send({4'b1101, sel, 1'b0});
      send(n);
      host.start();
      send({4'b1101, sel, 1'b1});
      host.xfer(8'hFF, 1'b1, 1'b0, r, k);
      check(r, RC);
      for (int m = 0; m < cnt; m++)
      begin
         i = n + m[7:0];
         host.xfer(8'hFF, 1'b1, m == cnt - 1, r, k);
         check(r, (i < 8'h0C) ? sh[i[3:0]] : 8'h00);
      end
      host.stop();
   endtask
   initial
   begin
      rng = 32'h40;
      rv = rnd();
      sel = rv[2:0];
      strap = rv[4:3];
      addr_select_pin = sel;
      pll_mode_strap = strap;
      oe_pin_n = 2'b00;
      rst_n = 1'b0;
      code = 2'b00;
      sh = '{8'h18, {strap, 6'h06}, 8'hFF, 8'hC7, 8'hFF, 8'h00, 8'h00,
         8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge sys_clk);
      addr_select_pin <= ~sel;
      check_outs();
      rd_blk(8'h00, 12);
      for (int k = 0; k < 2; k++)
      begin
         host.start();
         host.xfer(k == 0 ? {4'b1100, sel, 1'b0} : {4'b1101, ~sel, 1'b0},
            1'b0, 1'b0, d, a);
         check({7'h00, a}, 8'h00);
         host.stop();
      end
      for (int it = 0; it < 4; it++)
      begin
         rv = rnd();
         oe_pin_n <= (it == 0) ? 2'b11 : rv[1:0];
         code = it[1:0];
         wr_blk(8'h00, 5, 5);
         wr_blk(8'h0B, 1, 1);
         check_outs();
         rd_blk(8'h00, 5);
         rd_blk(8'h0A, 2);
      end
      wr_blk(8'h02, 3, 1);
      wr_blk(8'h01, 1, 2);
      check_outs();
      rd_blk(8'h00, 4);
      final_report();
   end
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      failures++;
      final_report();
   end
endmodule
